// ---- src/liu_pkg.sv ----
package liu_pkg;
  // Register window
  localparam logic [31:0] BASE_RST    = 32'hFEE00000;
  localparam int          WIN_LSB     = 12;
  localparam logic [11:0] OFS_CMD_LO  = 12'h300;
  localparam logic [11:0] OFS_CMD_HI  = 12'h310;
  localparam logic [11:0] OFS_TMR_LO  = 12'h180;
  localparam logic [11:0] OFS_TMR_HI  = 12'h1F0;
  localparam int          TMR_IDX_LSB = 4;
  localparam int          TMR_WORDS   = 8;
  // Command register fields
  localparam int          VEC_LSB     = 0;
  localparam int          TYPE_LSB    = 8;
  localparam int          BUSY_BIT    = 12;
  localparam int          TRIG_BIT    = 15;
  localparam int          SH_LSB      = 18;
  localparam int          DEST_LSB    = 24;
  // Message types
  localparam logic [2:0]  MT_FIXED    = 3'h0;
  localparam logic [2:0]  MT_SYSMGMT  = 3'h2;
  localparam logic [2:0]  MT_NMI      = 3'h4;
  localparam logic [2:0]  MT_RESTART  = 3'h5;
  localparam logic [2:0]  MT_STARTUP  = 3'h6;
  // Destination shorthand
  localparam logic [1:0]  SH_NONE     = 2'h0;
  localparam logic [1:0]  SH_SELF     = 2'h1;
  localparam logic [1:0]  SH_ALL      = 2'h2;
  localparam logic [3:0]  DEST_ALL    = 4'hF;
  // Message frame: type, trigger, destination, vector
  localparam int          FRAME_W     = 16;
  localparam int          FR_TYPE     = 13;
  localparam int          FR_TRIG     = 12;
  localparam int          FR_DEST     = 8;
  localparam int          FR_VEC      = 0;
  localparam logic [2:0]  FRAME_LAST  = 3'h7;
  localparam logic [2:0]  CNT_ONE     = 3'h1;
  // Read select
  localparam logic [1:0]  RS_ZERO     = 2'h0;
  localparam logic [1:0]  RS_LO       = 2'h1;
  localparam logic [1:0]  RS_HI       = 2'h2;
  localparam logic [1:0]  RS_TMR      = 2'h3;

  typedef enum logic {TX_IDLE, TX_SEND} liu_tx_t;
endpackage

// ---- src/liu_tmr_mem.sv ----
`timescale 1ns/10ps
module liu_tmr_mem
  import liu_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  // Single-bit write
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [4:0]  wbit,
  input  wire logic        wval,
  // Word read
  input  wire logic [2:0]  raddr,
  output logic      [31:0] rdata_q
);

  logic [31:0] mem_q [TMR_WORDS];

  // Cleared at reset so a read never returns unknown bits
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < TMR_WORDS; i++)
        mem_q[i] <= 32'h00000000;
      rdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      if (we)
        mem_q[waddr][wbit] <= wval;
      rdata_q <= mem_q[raddr];
    end
  end
endmodule

// ---- src/liu_unit.sv ----
`timescale 1ns/10ps
// Function
// RQ1: Command register write sends interprocessor message
// RQ2: Message targets peers or this unit itself
// RQ3: Received message delivered by vector, trigger mode
// RQ4: Accept router, peer and self messages
// RQ5: Router supplies programmed vector per pin
// RQ6: Disabled unit passes legacy controller interrupts
// RQ7: Fixed, nonblockable, restart, management, startup messages
// RQ8: Older variant uses dedicated three-wire bus
// RQ9: Newer variant uses system bus messages
// RQ10: Four-kilobyte window, reset base FEE00000
// RQ11: Software maps window as strict uncached
// RQ12: Same base everywhere, relocatable per unit
// RQ13: Window accesses serviced inside, no bus cycle
// RQ14: Software uses aligned 32-bit accesses
// RQ15: Other addresses go to memory path
// RQ16: Disabled unit neither sends nor accepts messages; a send already in flight when the unit is disabled still completes
module liu_unit
  import liu_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  // Configuration
  input  wire logic [3:0]  my_id,
  input  wire logic        unit_enable,
  input  wire logic        bus_mode,
  input  wire logic        base_load,
  input  wire logic [31:0] base_value,
  // Core access
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [31:0] acc_addr,
  input  wire logic [31:0] acc_wdata,
  output logic             acc_hit_q,
  output logic      [31:0] acc_rdata_q,
  // Memory path
  output logic             mem_req_q,
  output logic             mem_write_q,
  output logic      [31:0] mem_addr_q,
  output logic      [31:0] mem_wdata_q,
  // System bus message out
  output logic             tx_valid_q,
  input  wire logic        tx_ready,
  output logic      [15:0] tx_msg_q,
  // System bus message in
  input  wire logic        rx_valid,
  input  wire logic [2:0]  rx_type,
  input  wire logic        rx_trig,
  input  wire logic [3:0]  rx_dest,
  input  wire logic [7:0]  rx_vector,
  // Three-wire bus
  input  wire logic [2:0]  wire_in,
  output logic      [2:0]  wire_out_q,
  output logic      [2:0]  wire_oe_n_q,
  // Legacy controller
  input  wire logic        legacy_valid,
  input  wire logic [7:0]  legacy_vector,
  // Core delivery
  output logic             core_int_q,
  output logic      [7:0]  core_vector_q,
  output logic             core_trig_q,
  output logic             core_nmi_q,
  output logic             core_restart_q,
  output logic             core_sysmgmt_q,
  output logic             core_startup_q
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic in_win(input logic [31:0] a,
                                  input logic [31:0] b);
    return a[31:WIN_LSB] == b[31:WIN_LSB];
  endfunction

  function automatic logic dest_ok(input logic [3:0] d,
                                   input logic [3:0] id);
    return d == id || d == DEST_ALL;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [31:0]        base_q,      base_d;
  logic [31:0]        cmd_lo_q,    cmd_lo_d;
  logic [31:0]        cmd_hi_q,    cmd_hi_d;
  logic               ack1_q,      ack1_d;
  logic [1:0]         rsel_q,      rsel_d;
  logic               acc_hit_d,   mem_req_d,  mem_write_d;
  logic [31:0]        acc_rdata_d, mem_addr_d, mem_wdata_d;
  liu_tx_t            tx_st_q,     tx_st_d;
  logic               tx_valid_d;
  logic [15:0]        tx_msg_d,    tx_sh_q,    tx_sh_d;
  logic [2:0]         tx_cnt_q,    tx_cnt_d,   rx_cnt_q,   rx_cnt_d;
  logic [15:0]        rx_sh_q,     rx_sh_d,    self_msg_q, self_msg_d;
  logic               rx_done_q,   rx_done_d,  self_pend_q, self_pend_d;
  logic [2:0]         wire_out_d,  wire_oe_n_d;
  logic               core_int_d,  core_trig_d, core_nmi_d;
  logic               core_restart_d, core_sysmgmt_d, core_startup_d;
  logic [7:0]         core_vector_d;
  logic               hit, cmd_wr, send_go, ser_go, dv, tmr_we;
  logic [11:0]        off;
  logic [1:0]         sh;
  logic [15:0]        frame, dmsg;
  logic [7:0]         cmd_vec;
  logic [31:0]        base_aln, tmr_rdata;

  liu_tmr_mem u_tmr (
    .clock   (clock),
    .rst     (rst),
    .ce      (ce),
    .we      (tmr_we),
    .waddr   (dmsg[FR_VEC+5 +: 3]),
    .wbit    (dmsg[FR_VEC +: 5]),
    .wval    (dmsg[FR_TRIG]),
    .raddr   (off[TMR_IDX_LSB +: 3]),
    .rdata_q (tmr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    hit = acc_valid && in_win(acc_addr, base_q);
    off = acc_addr[WIN_LSB-1:0];
    sh = acc_wdata[SH_LSB +: 2];
    cmd_vec = acc_wdata[VEC_LSB +: 8];
    cmd_wr = hit && acc_write && off == OFS_CMD_LO;
    base_aln = {base_value[31:WIN_LSB], {WIN_LSB{1'b0}}};
    base_d = base_load ? base_aln : base_q; // RQ12
    cmd_lo_d = cmd_wr ? acc_wdata : cmd_lo_q;
    cmd_hi_d = (hit && acc_write && off == OFS_CMD_HI) ? acc_wdata
                                                        : cmd_hi_q;
    // Window hits answer two cycles later, nothing leaves the unit
    ack1_d = hit; // RQ13
    rsel_d = RS_ZERO;
    if (off == OFS_CMD_LO)
      rsel_d = RS_LO;
    else if (off == OFS_CMD_HI)
      rsel_d = RS_HI;
    else if (off >= OFS_TMR_LO && off <= OFS_TMR_HI)
      rsel_d = RS_TMR;
    acc_hit_d = ack1_q;
    case (rsel_q)
      RS_LO:   acc_rdata_d = cmd_lo_q | ({31'h0, tx_st_q == TX_SEND}
                                          << BUSY_BIT);
      RS_HI:   acc_rdata_d = cmd_hi_q;
      RS_TMR:  acc_rdata_d = tmr_rdata;
      default: acc_rdata_d = 32'h00000000;
    endcase
    mem_req_d = acc_valid && !hit; // RQ15
    mem_write_d = acc_write;
    mem_addr_d = acc_valid ? acc_addr : mem_addr_q;
    mem_wdata_d = acc_valid ? acc_wdata : mem_wdata_q;
    // Writes while a message is in flight still load the register but send nothing
    send_go = cmd_wr && unit_enable && tx_st_q == TX_IDLE; // RQ1 RQ16
    ser_go = send_go && !bus_mode && sh != SH_SELF;
    frame = {acc_wdata[TYPE_LSB +: 3], acc_wdata[TRIG_BIT],
             (sh == SH_NONE) ? cmd_hi_q[DEST_LSB +: 4] : DEST_ALL,
             cmd_vec};
    tx_st_d = tx_st_q;
    tx_valid_d = tx_valid_q;
    tx_msg_d = tx_msg_q;
    tx_sh_d = tx_sh_q;
    tx_cnt_d = tx_cnt_q;
    wire_out_d = wire_out_q;
    wire_oe_n_d = wire_oe_n_q;
    case (tx_st_q)
      TX_IDLE:
        if (send_go && sh != SH_SELF)
        begin
          tx_st_d = TX_SEND;
          tx_msg_d = frame;
          tx_cnt_d = 3'h0;
          if (bus_mode)
            tx_valid_d = 1'b1; // RQ9
          else
          begin
            tx_sh_d = frame << 2; // RQ8
            wire_out_d = {frame[FRAME_W-1 -: 2], 1'b0};
            wire_oe_n_d = 3'b000;
          end
        end
      TX_SEND:
        if (tx_valid_q)
        begin
          if (tx_ready)
          begin
            tx_valid_d = 1'b0;
            tx_st_d = TX_IDLE;
          end
        end
        else if (tx_cnt_q == FRAME_LAST)
        begin
          wire_oe_n_d = 3'b111;
          tx_st_d = TX_IDLE;
        end
        else
        begin
          wire_out_d = {tx_sh_q[FRAME_W-1 -: 2], 1'b0};
          tx_sh_d = tx_sh_q << 2;
          tx_cnt_d = tx_cnt_q + CNT_ONE;
        end
      default:
        tx_st_d = TX_IDLE;
    endcase
    // Own frames are not heard; frame wire low marks a frame
    rx_done_d = 1'b0;
    rx_sh_d = rx_sh_q;
    rx_cnt_d = 3'h0;
    if (!bus_mode && !wire_in[0] && wire_oe_n_q[0])
    begin
      rx_sh_d = {rx_sh_q[FRAME_W-3:0], wire_in[2:1]}; // RQ8
      rx_cnt_d = rx_cnt_q + CNT_ONE;
      rx_done_d = rx_cnt_q == FRAME_LAST;
    end
    // External messages win the slot; a self message waits
    dv = 1'b0;
    dmsg = self_msg_q;
    self_pend_d = self_pend_q;
    if (unit_enable)
    begin
      if (bus_mode && rx_valid && dest_ok(rx_dest, my_id))
      begin
        dv = 1'b1; // RQ4 RQ9
        dmsg = {rx_type, rx_trig, rx_dest, rx_vector};
      end
      else if (!bus_mode && rx_done_q
               && dest_ok(rx_sh_q[FR_DEST +: 4], my_id))
      begin
        dv = 1'b1; // RQ4
        dmsg = rx_sh_q;
      end
      else if (self_pend_q)
      begin
        dv = 1'b1;
        self_pend_d = 1'b0;
      end
    end
    else
      self_pend_d = 1'b0; // RQ16
    // Set after clear so a new self message is never lost
    self_msg_d = self_msg_q;
    if (send_go && (sh == SH_SELF || sh == SH_ALL))
    begin
      self_pend_d = 1'b1; // RQ2
      self_msg_d = frame;
    end
    core_int_d = 1'b0;
    core_nmi_d = 1'b0;
    core_restart_d = 1'b0;
    core_sysmgmt_d = 1'b0;
    core_startup_d = 1'b0;
    core_trig_d = core_trig_q;
    core_vector_d = core_vector_q;
    tmr_we = 1'b0;
    if (!unit_enable)
    begin
      if (legacy_valid)
      begin
        core_int_d = 1'b1; // RQ6
        core_vector_d = legacy_vector;
        core_trig_d = 1'b0;
      end
    end
    else if (dv)
    begin
      case (dmsg[FR_TYPE +: 3]) // RQ7
        MT_FIXED:
        begin
          core_int_d = 1'b1; // RQ3
          core_vector_d = dmsg[FR_VEC +: 8];
          core_trig_d = dmsg[FR_TRIG];
          tmr_we = 1'b1;
        end
        MT_NMI:     core_nmi_d = 1'b1;
        MT_RESTART: core_restart_d = 1'b1;
        MT_SYSMGMT: core_sysmgmt_d = 1'b1;
        MT_STARTUP:
        begin
          core_startup_d = 1'b1;
          core_vector_d = dmsg[FR_VEC +: 8];
        end
        default:    core_int_d = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      base_q <= BASE_RST; // RQ10
      {cmd_lo_q, cmd_hi_q, acc_rdata_q} <= '0;
      {ack1_q, acc_hit_q, mem_req_q, mem_write_q} <= '0;
      {mem_addr_q, mem_wdata_q, rsel_q} <= '0;
      tx_st_q <= TX_IDLE;
      {tx_valid_q, tx_msg_q, tx_sh_q, tx_cnt_q} <= '0;
      {rx_sh_q, rx_cnt_q, rx_done_q} <= '0;
      {self_msg_q, self_pend_q, wire_out_q} <= '0;
      wire_oe_n_q <= 3'b111;
      {core_int_q, core_vector_q, core_trig_q} <= '0;
      {core_nmi_q, core_restart_q, core_sysmgmt_q, core_startup_q} <= '0;
    end
    else if (ce)
    begin
      base_q <= base_d;
      cmd_lo_q <= cmd_lo_d;
      cmd_hi_q <= cmd_hi_d;
      ack1_q <= ack1_d;
      rsel_q <= rsel_d;
      acc_hit_q <= acc_hit_d;
      acc_rdata_q <= acc_rdata_d;
      mem_req_q <= mem_req_d;
      mem_write_q <= mem_write_d;
      mem_addr_q <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      tx_st_q <= tx_st_d;
      tx_valid_q <= tx_valid_d;
      tx_msg_q <= tx_msg_d;
      tx_sh_q <= tx_sh_d;
      tx_cnt_q <= tx_cnt_d;
      rx_sh_q <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      rx_done_q <= rx_done_d;
      self_msg_q <= self_msg_d;
      self_pend_q <= self_pend_d;
      wire_out_q <= wire_out_d;
      wire_oe_n_q <= wire_oe_n_d;
      core_int_q <= core_int_d;
      core_vector_q <= core_vector_d;
      core_trig_q <= core_trig_d;
      core_nmi_q <= core_nmi_d;
      core_restart_q <= core_restart_d;
      core_sysmgmt_q <= core_sysmgmt_d;
      core_startup_q <= core_startup_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks assume ce held high
  AST_SEND: assert property (@(posedge clock) disable iff (rst || !ce) // RQ1
    send_go && bus_mode && sh != SH_SELF |=> tx_valid_q
      && tx_msg_q[FR_VEC +: 8] == $past(cmd_vec))
    else $error("command write did not issue a message");
  AST_SELF: assert property (@(posedge clock) disable iff (rst || !ce) // RQ2
    send_go && sh == SH_SELF |=> self_pend_q && tx_st_q == TX_IDLE)
    else $error("self message not queued");
  AST_RXVEC: assert property (@(posedge clock) disable iff (rst || !ce) // RQ3
    unit_enable && bus_mode && rx_valid && dest_ok(rx_dest, my_id)
      && rx_type == MT_FIXED |=> core_int_q
      && core_vector_q == $past(rx_vector) && core_trig_q == $past(rx_trig))
    else $error("fixed message vector or trigger lost");
  AST_LEGACY: assert property (@(posedge clock) disable iff (rst || !ce) // RQ6
    !unit_enable && legacy_valid |=> core_int_q
      && core_vector_q == $past(legacy_vector))
    else $error("legacy interrupt not passed through");
  AST_NMI: assert property (@(posedge clock) disable iff (rst || !ce) // RQ7
    unit_enable && dv && dmsg[FR_TYPE +: 3] == MT_NMI
      |=> core_nmi_q && !core_int_q)
    else $error("nonblockable message mishandled");
  AST_WIRE: assert property (@(posedge clock) disable iff (rst || !ce) // RQ8
    ser_go |=> !wire_oe_n_q[0] [*8] ##1 wire_oe_n_q[0])
    else $error("three-wire frame length wrong");
  AST_HIT: assert property (@(posedge clock) disable iff (rst || !ce) // RQ13
    acc_valid && in_win(acc_addr, base_q) |=> !mem_req_q ##1 acc_hit_q)
    else $error("window access left the unit");
  AST_MISS: assert property (@(posedge clock) disable iff (rst || !ce) // RQ15
    acc_valid && !in_win(acc_addr, base_q)
      |=> mem_req_q && !acc_hit_q && mem_addr_q == $past(acc_addr))
    else $error("outside access not passed on");
  AST_BASE: assert property (@(posedge clock) disable iff (rst || !ce) // RQ12
    base_load |=> base_q == $past(base_aln))
    else $error("base not relocated");
  AST_DIS: assert property (@(posedge clock) disable iff (rst || !ce) // RQ16
    !unit_enable && tx_st_q == TX_IDLE |=> tx_st_q == TX_IDLE && !tx_valid_q
      && !core_nmi_q && !core_sysmgmt_q)
    else $error("disabled unit handled a message");
endmodule

// ---- verif/liu_peer_model.sv ----
`timescale 1ns/10ps
module liu_peer_model
  import liu_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // Message sink
  input  wire logic        tx_valid_q,
  output logic             tx_ready,
  input  wire logic [15:0] tx_msg_q,
  // Message source
  output logic             rx_valid,
  output logic      [2:0]  rx_type,
  output logic             rx_trig,
  output logic      [3:0]  rx_dest,
  output logic      [7:0]  rx_vector,
  // Three-wire bus
  input  wire logic [2:0]  wire_out_q,
  input  wire logic [2:0]  wire_oe_n_q,
  output logic      [2:0]  wire_in
);
  ////////////////////////////////////////
  int          stall = 0;
  int          wait_cnt = 0;
  logic [15:0] got_msg = 16'h0;
  logic        drv = 1'h0;
  logic [2:0]  drv_val = 3'h7;

  initial
  begin
    tx_ready = 1'h0;
    rx_valid = 1'h0;
    {rx_type, rx_trig, rx_dest, rx_vector} = 16'h0;
  end

  // Sink stalls for a chosen count, so holding is really exercised
  always @(negedge clock)
  begin
    wait_cnt = tx_valid_q ? wait_cnt + 1 : 0;
    tx_ready <= tx_valid_q && (wait_cnt > stall);
  end

  always @(posedge clock)
    if (tx_valid_q && tx_ready)
      got_msg <= tx_msg_q;

  ////////////////////////////////////////
  // Pulled-up bus: a released wire reads high
  assign wire_in = (~wire_oe_n_q & wire_out_q)
                 | (wire_oe_n_q & (drv ? drv_val : 3'h7));

  // Programmed vector goes out with each message
  task automatic send_bus(input logic [2:0] t, input logic g,
                          input logic [3:0] d, input logic [7:0] v);
    rx_valid = 1'h1;
    {rx_type, rx_trig, rx_dest, rx_vector} = {t, g, d, v};
    @(negedge clock);
    rx_valid = 1'h0;
    // Inverse, so a stale field can never pass for a match
    {rx_type, rx_trig, rx_dest, rx_vector} = ~{t, g, d, v};
  endtask

  // Frame low, two data bits a cycle, high pair first
  task automatic send_wire(input logic [15:0] f, input int len);
    for (int i = 0; i < len; i++)
    begin
      drv = 1'h1;
      drv_val = {f[15 - 2 * i -: 2], 1'h0};
      @(negedge clock);
    end
    drv = 1'h0;
  endtask
endmodule

// ---- verif/tb_liu_unit.sv ----
`timescale 1ns/10ps
module tb_liu_unit
  import liu_pkg::*;
();
  ////////////////////////////////////////
  logic        clock = 1'h0;
  logic        rst = 1'h1;
  logic        unit_enable = 1'h1;
  logic        bus_mode = 1'h1;
  logic        base_load = 1'h0;
  logic [31:0] base_value = 32'h0;
  logic        acc_valid = 1'h0;
  logic        acc_write = 1'h0;
  logic [31:0] acc_addr = 32'h0;
  logic [31:0] acc_wdata = 32'h0;
  logic        legacy_valid = 1'h0;
  logic [7:0]  legacy_vector = 8'h0;
  logic        acc_hit_q, mem_req_q, mem_write_q, tx_valid_q, tx_ready;
  logic        rx_valid, rx_trig, core_int_q, core_trig_q;
  logic        core_nmi_q, core_restart_q, core_sysmgmt_q, core_startup_q;
  logic [31:0] acc_rdata_q, mem_addr_q, mem_wdata_q, rdata;
  logic [31:0] base = BASE_RST;
  logic [15:0] tx_msg_q;
  logic [2:0]  rx_type, wire_in, wire_out_q, wire_oe_n_q;
  logic [3:0]  rx_dest;
  logic [7:0]  rx_vector, core_vector_q;
  logic [4:0]  core_flags;
  int          err_count = 0;
  int          num_checks = 0;

  assign core_flags = {core_int_q, core_nmi_q, core_restart_q,
                       core_sysmgmt_q, core_startup_q};

  always #20 clock = ~clock;

  liu_unit liu_unit_i (.clock(clock), .rst(rst), .ce(1'h1),
    .my_id(4'h3), .unit_enable(unit_enable), .bus_mode(bus_mode),
    .base_load(base_load), .base_value(base_value),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_hit_q(acc_hit_q),
    .acc_rdata_q(acc_rdata_q), .mem_req_q(mem_req_q),
    .mem_write_q(mem_write_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .tx_valid_q(tx_valid_q),
    .tx_ready(tx_ready), .tx_msg_q(tx_msg_q), .rx_valid(rx_valid),
    .rx_type(rx_type), .rx_trig(rx_trig), .rx_dest(rx_dest),
    .rx_vector(rx_vector), .wire_in(wire_in), .wire_out_q(wire_out_q),
    .wire_oe_n_q(wire_oe_n_q), .legacy_valid(legacy_valid),
    .legacy_vector(legacy_vector), .core_int_q(core_int_q),
    .core_vector_q(core_vector_q), .core_trig_q(core_trig_q),
    .core_nmi_q(core_nmi_q), .core_restart_q(core_restart_q),
    .core_sysmgmt_q(core_sysmgmt_q), .core_startup_q(core_startup_q));

  liu_peer_model liu_peer_model_i (.clock(clock), .tx_valid_q(tx_valid_q),
    .tx_ready(tx_ready), .tx_msg_q(tx_msg_q), .rx_valid(rx_valid),
    .rx_type(rx_type), .rx_trig(rx_trig), .rx_dest(rx_dest),
    .rx_vector(rx_vector), .wire_out_q(wire_out_q),
    .wire_oe_n_q(wire_oe_n_q), .wire_in(wire_in));

  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Word access on a 16-byte slot, one cycle of valid, never cached
  task automatic req(input logic w, input logic [31:0] a, d);
    acc_valid = 1'h1;
    acc_write = w;
    acc_addr = a;
    acc_wdata = d;
    @(negedge clock);
    acc_valid = 1'h0;
    acc_addr = ~a;
    acc_wdata = ~d;
  endtask

  task automatic acc(input logic w, input logic [31:0] a, d,
                     input logic hit);
    req(w, a, d);
    check(32'(mem_req_q), 32'(!hit));
    check(32'(acc_hit_q), 32'h0);
    if (!hit)
    begin
      check(mem_addr_q, a);
      check({mem_wdata_q[30:0], mem_write_q}, {d[30:0], w});
    end
    @(negedge clock);
    check(32'(acc_hit_q), 32'(hit));
    check(32'(mem_req_q), 32'h0);
    rdata = acc_rdata_q;
  endtask

  ////////////////////////////////////////
  task automatic t_window;
    check(32'(wire_oe_n_q), 32'h7);
    acc(1'h0, BASE_RST + OFS_CMD_LO, 32'h0, 1'h1);
    check(rdata, 32'h0);
    acc(1'h0, BASE_RST + 32'hFF0, 32'h0, 1'h1);
    acc(1'h1, BASE_RST + 32'h1000, 32'hA5A5A5A5, 1'h0);
    acc(1'h0, BASE_RST - 32'h10, 32'h0, 1'h0);
    base_value = 32'h12345ABC;
    base_load = 1'h1;
    @(negedge clock);
    base_load = 1'h0;
    acc(1'h0, BASE_RST + OFS_CMD_LO, 32'h0, 1'h0);
    base = 32'h12345000;
    acc(1'h0, base + OFS_CMD_LO, 32'h0, 1'h1);
  endtask

  // Every message type, stalls growing, last one to all but self
  task automatic t_send;
    logic [2:0]  ty [5];
    logic [2:0]  t;
    logic [3:0]  dst;
    logic [15:0] e;
    logic [31:0] lo;
    ty = '{MT_FIXED, MT_SYSMGMT, MT_NMI, MT_RESTART, MT_STARTUP};
    acc(1'h1, base + OFS_CMD_HI, 32'h05000000, 1'h1);
    for (int i = 0; i < 6; i++)
    begin
      t = (i < 5) ? ty[i] : MT_FIXED;
      dst = (i < 5) ? 4'h5 : DEST_ALL;
      lo = 32'h40 + 32'(i) + (32'(t) << TYPE_LSB)
         + (32'(i % 2) << TRIG_BIT) + (32'(i / 5 * 3) << SH_LSB);
      e = {t, lo[TRIG_BIT], dst, lo[7:0]};
      liu_peer_model_i.stall = i;
      req(1'h1, base + OFS_CMD_LO, lo);
      check(32'(tx_valid_q), 32'h1);
      check(32'(tx_msg_q), 32'(e));
      for (int k = 0; k < 20 && tx_valid_q !== 1'h0; k++)
        @(negedge clock);
      check(32'(liu_peer_model_i.got_msg), 32'(e));
    end
    acc(1'h0, base + OFS_CMD_LO, 32'h0, 1'h1);
    check(rdata, lo);
  endtask

  task automatic t_recv;
    logic [2:0] ty [5];
    logic [4:0] fl [5];
    ty = '{MT_FIXED, MT_SYSMGMT, MT_NMI, MT_RESTART, MT_STARTUP};
    fl = '{5'h10, 5'h02, 5'h08, 5'h04, 5'h01};
    for (int i = 0; i < 5; i++)
    begin
      liu_peer_model_i.send_bus(ty[i], 1'h1, i % 2 ? DEST_ALL : 4'h3,
                                8'h80 + 8'(i));
      check(32'(core_flags), 32'(fl[i]));
      if (i % 4 == 0)
        check({core_trig_q, core_vector_q}, 32'h180 + 32'(i));
      // Let an edge pass so the pulse is not raised as it drops
      @(negedge clock);
    end
    liu_peer_model_i.send_bus(MT_FIXED, 1'h0, 4'h7, 8'h99);
    check(32'(core_flags), 32'h0);
    // Self message lands two cycles after the write
    req(1'h1, base + OFS_CMD_LO, 32'h00040077);
    check(32'(core_int_q), 32'h0);
    @(negedge clock);
    check({core_int_q, core_vector_q}, 32'h177);
    // Vector 80 came in level-triggered, the others left no mark
    acc(1'h0, base + OFS_TMR_LO + 32'h40, 32'h0, 1'h1);
    check(rdata, 32'h1);
    repeat (4) @(negedge clock);
  endtask

  task automatic t_disable;
    unit_enable = 1'h0;
    legacy_vector = 8'h21;
    legacy_valid = 1'h1;
    @(negedge clock);
    legacy_valid = 1'h0;
    legacy_vector = 8'hDE;
    check({core_int_q, core_trig_q, core_vector_q}, 32'h221);
    req(1'h1, base + OFS_CMD_LO, 32'h00000033);
    liu_peer_model_i.send_bus(MT_NMI, 1'h0, 4'h3, 8'h02);
    check(32'(tx_valid_q), 32'h0);
    check(32'(core_flags), 32'h0);
    unit_enable = 1'h1;
  endtask

  task automatic t_wire;
    logic [15:0] got;
    logic [2:0]  oe;
    bus_mode = 1'h0;
    oe = 3'h0;
    got = 16'h0;
    req(1'h1, base + OFS_CMD_LO, 32'h0000805A);
    for (int i = 0; i < 8; i++)
    begin
      oe = oe | wire_oe_n_q | wire_out_q & 3'h1;
      got = {got[13:0], wire_out_q[2:1]};
      @(negedge clock);
    end
    check(32'(oe), 32'h0);
    check(32'(got), 32'h155A);
    check(32'(wire_oe_n_q), 32'h7);
    liu_peer_model_i.send_wire(16'h0366, 8);
    @(negedge clock);
    check({core_int_q, core_vector_q}, 32'h166);
    // A cut-short frame must never reach the core
    oe = 3'h0;
    liu_peer_model_i.send_wire(16'h0377, 5);
    repeat (5)
    begin
      @(negedge clock);
      oe = oe | 3'(core_int_q);
    end
    check(32'(oe), 32'h0);
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge clock);
    rst = 1'h0;
    t_window;
    t_send;
    t_recv;
    t_disable;
    t_wire;
    finish_test;
  end

  // Whole run is about a hundred cycles; far more means a hang
  initial
  begin
    #(40 * 3000);
    err_count++;
    finish_test;
  end
endmodule
